// File: common/ilo_pkg.sv
// Purpose: constants and types for the interleave lane order block
// Assumes: 10 MHz clock, branch converters modelled as sample words arriving in parallel
// Notes: mode codes equal the value written to the mode register
// Contract
// - Quad mode puts channel k first sample on lane ka from branch 2k-1, second on kb from 2k.
// - Dual mode maps lanes 1a,1b,2a,2b to branches 1,3,2,4 and 3a,3b,4a,4b to 5,7,6,8.
// - Single mode puts eight consecutive samples on lanes 1a..4b from branches 1,6,2,5,8,3,7,4.
// - Eight branches each have their own fine-gain correction, grouped by mode into one, two or four converters.
// - Output codes are offset binary, zero at minus full scale and 255 at plus full scale.
// - Frame and bit clocks for the output lanes are made inside the device.
// - Sampling clocks come from the single clock input through dividers set by the mode.
// - A two-bit setting switches the common-mode buffer off or changes its drive.
// - Only the rising edge of the input clock is used.
package ilo_pkg;
    localparam int NBR = 8;
    localparam int W = 8;
    localparam logic [15:0] MODE_SINGLE = 16'h0001;
    localparam logic [15:0] MODE_DUAL = 16'h0102;
    localparam logic [15:0] MODE_QUAD = 16'h0204;
    localparam logic [2:0] DIV_SINGLE = 3'h1;
    localparam logic [2:0] DIV_DUAL = 3'h2;
    localparam logic [2:0] DIV_QUAD = 3'h4;
    localparam logic [7:0] CODE_MIN = 8'h00;
    localparam logic [7:0] CODE_MAX = 8'hFF;
    localparam logic [1:0] VCM_DRIVE_RST = 2'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] FRAME_HIGH_SLOTS = 3'h4;
    localparam logic [12:0] GAIN_UNITY = 13'h0000;
    localparam int GAIN_SHIFT = 13;
    typedef enum logic [1:0] {ILO_SINGLE, ILO_DUAL, ILO_QUAD} ilo_mode_t;
    // lane index 0..7 = 1a,1b,2a,2b,3a,3b,4a,4b; values are branch index 0..7
    localparam logic [23:0] MAP_QUAD = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    localparam logic [23:0] MAP_DUAL = {3'h7, 3'h5, 3'h6, 3'h4, 3'h3, 3'h1, 3'h2, 3'h0};
    localparam logic [23:0] MAP_SINGLE = {3'h3, 3'h6, 3'h2, 3'h7, 3'h4, 3'h1, 3'h5, 3'h0};
endpackage

// File: core/ilo_fine_gain.sv
`timescale 1ns/1ps
// Purpose: per-branch digital fine-gain correction, one registered stage
// Assumes: signed 13-bit gain, out = in * (1 + g / 2^13)
// Notes: result saturates to the offset-binary code range
module ilo_fine_gain (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // data
    input wire logic [7:0] din,
    input wire logic signed [12:0] gain,
    output logic [7:0] dout
);
    typedef struct packed {
        logic [7:0] dout;
    } ilo_fg_state_t;
    ilo_fg_state_t st_r;
    ilo_fg_state_t st_nxt;
    logic signed [22:0] prod;
    logic signed [23:0] sum;
    assign dout = st_r.dout;
    always_comb begin
        prod = 23'(signed'({1'b0, din}) * gain);
        sum = 24'(signed'({1'b0, din})) + 24'(prod >>> ilo_pkg::GAIN_SHIFT);
        st_nxt = st_r;
        // clamp keeps the offset-binary span intact
        if (sum < 0) begin
            st_nxt.dout = ilo_pkg::CODE_MIN;
        end else if (sum > 24'(ilo_pkg::CODE_MAX)) begin
            st_nxt.dout = ilo_pkg::CODE_MAX;
        end else begin
            st_nxt.dout = sum[7:0];
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// File: core/ilo_lane_order.sv
`timescale 1ns/1ps
// Purpose: maps eight fine-gain branches onto eight serial lanes per channel mode
// Assumes: branch words arrive in parallel with branch_valid; mode only changes in power-down
// Notes: one frame = 8 bit slots, msb first; bit_clock is an enable-rate square wave
module ilo_lane_order (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // configuration
    input wire logic [15:0] mode_word,
    input wire logic power_down,
    input wire logic [1:0] vcm_drive_in,
    input wire logic [103:0] fine_gain,
    // branch samples
    input wire logic [63:0] branch_data,
    input wire logic branch_valid,
    // link
    output logic frame_clock,
    output logic bit_clock,
    output logic [7:0] lanes,
    // status
    output logic [1:0] vcm_buffer_drive,
    output logic [2:0] clock_div,
    output logic [1:0] mode_active
);
    typedef struct packed {
        ilo_pkg::ilo_mode_t mode;
        logic [2:0] div;
        logic [1:0] vcm;
        logic [2:0] bitcnt;
        logic running;
        logic bclk;
        logic [63:0] shreg;
        logic [63:0] pend;
        logic pend_v;
        logic gv;
    } ilo_state_t;
    ilo_state_t st_r;
    ilo_state_t st_nxt;
    logic [63:0] gained;
    logic [23:0] map;
    logic [63:0] ordered;
    genvar gi;
    // one correction per branch
    generate
        for (gi = 0; gi < ilo_pkg::NBR; gi++) begin : g_br
            ilo_fine_gain u_fg (
                .clock(clock),
                .nrst(nrst),
                .din(branch_data[gi*8 +: 8]),
                .gain(fine_gain[gi*13 +: 13]),
                .dout(gained[gi*8 +: 8])
            );
        end
    endgenerate
    always_comb begin
        unique case (st_r.mode)
            ilo_pkg::ILO_QUAD: map = ilo_pkg::MAP_QUAD;
            ilo_pkg::ILO_DUAL: map = ilo_pkg::MAP_DUAL;
            default: map = ilo_pkg::MAP_SINGLE;
        endcase
    end
    generate
        for (gi = 0; gi < ilo_pkg::NBR; gi++) begin : g_ln
            assign ordered[gi*8 +: 8] = gained[map[gi*3 +: 3]*8 +: 8];
        end
    endgenerate
    always_comb begin
        st_nxt = st_r;
        st_nxt.vcm = vcm_drive_in;
        st_nxt.gv = branch_valid && !power_down;
        // mode and divider only follow the word while powered down
        if (power_down) begin
            st_nxt.running = 1'b0;
            st_nxt.pend_v = 1'b0;
            st_nxt.bitcnt = '0;
            st_nxt.bclk = 1'b0;
            unique case (mode_word)
                ilo_pkg::MODE_SINGLE: begin
                    st_nxt.mode = ilo_pkg::ILO_SINGLE;
                    st_nxt.div = ilo_pkg::DIV_SINGLE;
                end
                ilo_pkg::MODE_DUAL: begin
                    st_nxt.mode = ilo_pkg::ILO_DUAL;
                    st_nxt.div = ilo_pkg::DIV_DUAL;
                end
                ilo_pkg::MODE_QUAD: begin
                    st_nxt.mode = ilo_pkg::ILO_QUAD;
                    st_nxt.div = ilo_pkg::DIV_QUAD;
                end
                default: begin
                end
            endcase
        end else begin
            if (st_r.gv) begin
                st_nxt.pend = ordered;
                st_nxt.pend_v = 1'b1;
            end
            // link clocks made internally from the one clock
            st_nxt.bclk = !st_r.bclk;
            if (st_r.bclk) begin
                if (st_r.bitcnt == ilo_pkg::BIT_LAST || !st_r.running) begin
                    st_nxt.bitcnt = '0;
                    if (st_nxt.pend_v) begin
                        st_nxt.shreg = st_nxt.pend;
                        st_nxt.pend_v = 1'b0;
                        st_nxt.running = 1'b1;
                    end else if (!st_r.running) begin
                        st_nxt.shreg = '0;
                    end
                end else begin
                    st_nxt.bitcnt = st_r.bitcnt + 3'h1;
                    for (int i = 0; i < ilo_pkg::NBR; i++) begin
                        st_nxt.shreg[i*8 +: 8] = {st_r.shreg[i*8 +: 7], 1'b0};
                    end
                end
            end
        end
    end
    // rising edge only
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_r <= '{mode: ilo_pkg::ILO_SINGLE, div: ilo_pkg::DIV_SINGLE,
                vcm: ilo_pkg::VCM_DRIVE_RST, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end
    generate
        for (gi = 0; gi < ilo_pkg::NBR; gi++) begin : g_out
            assign lanes[gi] = st_r.shreg[gi*8 + 7];
        end
    endgenerate
    assign bit_clock = st_r.bclk;
    assign frame_clock = st_r.running && (st_r.bitcnt < ilo_pkg::FRAME_HIGH_SLOTS);
    assign vcm_buffer_drive = st_r.vcm;
    assign clock_div = st_r.div;
    assign mode_active = st_r.mode;

    property p_div_follows;
        @(posedge clock) disable iff (!nrst)
        (st_r.mode == ilo_pkg::ILO_QUAD) |-> (clock_div == ilo_pkg::DIV_QUAD);
    endproperty
    a_div_follows: assert property (p_div_follows) else $error("divider off mode");
    property p_div_dual;
        @(posedge clock) disable iff (!nrst)
        (st_r.mode == ilo_pkg::ILO_DUAL) |-> (clock_div == ilo_pkg::DIV_DUAL);
    endproperty
    a_div_dual: assert property (p_div_dual) else $error("dual divider off mode");
    property p_div_single;
        @(posedge clock) disable iff (!nrst)
        (st_r.mode == ilo_pkg::ILO_SINGLE) |-> (clock_div == ilo_pkg::DIV_SINGLE);
    endproperty
    a_div_single: assert property (p_div_single) else $error("single divider off");
    property p_mode_take;
        @(posedge clock) disable iff (!nrst)
        power_down && mode_word == ilo_pkg::MODE_QUAD |=> mode_active == ilo_pkg::ILO_QUAD;
    endproperty
    a_mode_take: assert property (p_mode_take) else $error("quad mode not taken");
    property p_mode_hold;
        @(posedge clock) disable iff (!nrst)
        !$past(power_down) |-> $stable(mode_active);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed while active");
    property p_vcm;
        @(posedge clock) disable iff (!nrst) 1'b1 |=> vcm_buffer_drive == $past(vcm_drive_in);
    endproperty
    a_vcm: assert property (p_vcm) else $error("vcm drive not taken");
    property p_bclk;
        @(posedge clock) disable iff (!nrst)
        !power_down ##1 !power_down |-> bit_clock != $past(bit_clock);
    endproperty
    a_bclk: assert property (p_bclk) else $error("bit clock stuck");
    // a cut frame is allowed, so power-down ends the check
    property p_frame_len;
        @(posedge clock) disable iff (!nrst || power_down)
        $rose(frame_clock) |-> frame_clock [*8] ##1 !frame_clock;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame clock width wrong");
    property p_bit_stand;
        @(posedge clock) disable iff (!nrst)
        !$past(bit_clock) |-> $stable(lanes);
    endproperty
    a_bit_stand: assert property (p_bit_stand) else $error("lane moved mid bit");
    property p_quad_map;
        @(posedge clock) disable iff (!nrst)
        st_r.mode == ilo_pkg::ILO_QUAD |-> ordered[15:8] == gained[15:8];
    endproperty
    a_quad_map: assert property (p_quad_map) else $error("quad lane 1b wrong");
    property p_quad_map_4b;
        @(posedge clock) disable iff (!nrst)
        st_r.mode == ilo_pkg::ILO_QUAD |-> ordered[63:56] == gained[63:56];
    endproperty
    a_quad_map_4b: assert property (p_quad_map_4b) else $error("quad lane 4b wrong");
    property p_dual_map;
        @(posedge clock) disable iff (!nrst)
        st_r.mode == ilo_pkg::ILO_DUAL |-> ordered[15:8] == gained[23:16];
    endproperty
    a_dual_map: assert property (p_dual_map) else $error("dual lane 1b wrong");
    property p_dual_map_3b;
        @(posedge clock) disable iff (!nrst)
        st_r.mode == ilo_pkg::ILO_DUAL |-> ordered[47:40] == gained[55:48];
    endproperty
    a_dual_map_3b: assert property (p_dual_map_3b) else $error("dual lane 3b wrong");
    property p_single_map;
        @(posedge clock) disable iff (!nrst)
        st_r.mode == ilo_pkg::ILO_SINGLE |-> ordered[15:8] == gained[47:40];
    endproperty
    a_single_map: assert property (p_single_map) else $error("single lane 1b wrong");
    property p_single_map_3a;
        @(posedge clock) disable iff (!nrst)
        st_r.mode == ilo_pkg::ILO_SINGLE |-> ordered[39:32] == gained[63:56];
    endproperty
    a_single_map_3a: assert property (p_single_map_3a) else $error("single lane 3a wrong");
    property p_pd_quiet;
        @(posedge clock) disable iff (!nrst) power_down |=> !frame_clock && !bit_clock;
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("link active in power-down");
    c_quad: cover property (@(posedge clock) mode_active == ilo_pkg::ILO_QUAD && frame_clock);
    c_dual: cover property (@(posedge clock) mode_active == ilo_pkg::ILO_DUAL && frame_clock);
    c_single: cover property (@(posedge clock) mode_active == ilo_pkg::ILO_SINGLE && frame_clock);
    c_cut: cover property (@(posedge clock) power_down && frame_clock);
endmodule

// File: verif/ilo_rx_model.sv
// Purpose: receiver on the far side of the serial lanes
// Assumes: frame_clock rises with the msb of each frame; each bit stands two clocks
// Notes: samples mid-bit, never on the edge that moves the lanes
`timescale 1ns/1ps
module ilo_rx_model (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // link from the device, no clock goes back
    input wire logic power_down,
    input wire logic frame_clock,
    input wire logic [7:0] lanes,
    // captured words, lane i at [i*8+:8]
    output logic [63:0] rx_words,
    output logic [15:0] rx_frames
);
    logic fc_q;
    logic [63:0] sh;
    logic [63:0] sh_nxt;
    int slot;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            // lane order is time order within a channel
            sh_nxt[i*8+:8] = {sh[i*8+:7], lanes[i]};
        end
    end
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            slot <= -1;
            fc_q <= 1'b0;
            sh <= '0;
            rx_frames <= '0;
            rx_words <= '0;
        end else if (power_down) begin
            // drop any partial frame so the next mode starts clean
            slot <= -1;
            fc_q <= 1'b0;
        end else begin
            fc_q <= frame_clock;
            if (frame_clock && !fc_q) begin
                sh <= sh_nxt;
                slot <= 1;
            end else if (slot >= 0) begin
                if (slot % 2 == 0) begin
                    sh <= sh_nxt;
                end
                if (slot == 14) begin
                    rx_words <= sh_nxt;
                    rx_frames <= rx_frames + 16'h0001;
                    slot <= -1;
                end else begin
                    slot <= slot + 1;
                end
            end
        end
    end
endmodule

// File: verif/tb_top.sv
// Purpose: self-checking bench for the lane order block
// Assumes: unity gain unless a test sets it; mode changes made in power-down
// Notes: each data test re-enters power-down so the receiver resyncs
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] mode_word = 16'h0001;
    logic power_down = 1'b1;
    logic [1:0] vcm_drive_in = 2'h0;
    logic [103:0] fine_gain = '0;
    logic [63:0] branch_data = '0;
    logic branch_valid = 1'b0;
    logic frame_clock, bit_clock;
    logic [7:0] lanes;
    logic [1:0] vcm_buffer_drive, mode_active;
    logic [2:0] clock_div;
    logic [63:0] rx_words;
    logic [15:0] rx_frames;
    int mismatches = 0;
    int num_checks = 0;
    int maps[3][8] = '{'{1, 6, 2, 5, 8, 3, 7, 4}, '{1, 3, 2, 4, 5, 7, 6, 8},
        '{1, 2, 3, 4, 5, 6, 7, 8}};
    logic [15:0] mw[3] = '{16'h0001, 16'h0102, 16'h0204};
    logic [2:0] dv[3] = '{3'h1, 3'h2, 3'h4};
    initial forever #50 clock = ~clock;
    ilo_lane_order u_dut (.clock(clock), .nrst(nrst), .mode_word(mode_word),
        .power_down(power_down), .vcm_drive_in(vcm_drive_in), .fine_gain(fine_gain),
        .branch_data(branch_data), .branch_valid(branch_valid), .frame_clock(frame_clock),
        .bit_clock(bit_clock), .lanes(lanes), .vcm_buffer_drive(vcm_buffer_drive),
        .clock_div(clock_div), .mode_active(mode_active));
    ilo_rx_model u_rx (.clock(clock), .nrst(nrst), .power_down(power_down),
        .frame_clock(frame_clock), .lanes(lanes), .rx_words(rx_words), .rx_frames(rx_frames));
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic set_mode(input logic [15:0] m);
        power_down = 1'b1;
        mode_word = m;
        tick(2);
    endtask
    // leaves power-down and presents one sample set in the same cycle
    task automatic send(input logic [63:0] d);
        logic [15:0] f0;
        f0 = rx_frames;
        branch_data = d;
        power_down = 1'b0;
        branch_valid = 1'b1;
        tick(1);
        branch_valid = 1'b0;
        for (int i = 0; i < 200 && rx_frames === f0; i++)
            tick(1);
        if (rx_frames === f0) begin
            mismatches++;
            $display("ERROR t=%0t frame wait ran out seen=%h exp=%h", $time, f0, f0 + 1);
            close_out();
        end
    endtask
    task automatic t_modes;
        logic [63:0] d, e;
        d = 64'h8877665544332211;
        for (int m = 0; m < 3; m++) begin
            set_mode(mw[m]);
            check(64'(mode_active), 64'(m));
            check(64'(clock_div), 64'(dv[m]));
            send(d);
            for (int i = 0; i < 8; i++)
                e[i*8+:8] = d[(maps[m][i]-1)*8+:8];
            check(rx_words, e);
        end
        mode_word = 16'h0001;
        tick(3);
        check(64'(mode_active), 64'h2);
        set_mode(16'h1234);
        check(64'(mode_active), 64'h2);
        $display("test modes done");
    endtask
    task automatic t_gain;
        set_mode(16'h0204);
        fine_gain[0+:13] = 13'h0800;
        fine_gain[13+:13] = 13'h1000;
        fine_gain[26+:13] = 13'h0FFF;
        send(64'h8877665544F08080);
        check(rx_words, 64'h8877665544FF40A0);
        fine_gain = '0;
        $display("test gain done");
    endtask
    task automatic t_misc;
        int n;
        n = 0;
        for (int i = 0; i < 16; i++) begin
            n += (bit_clock === 1'b1);
            tick(1);
        end
        check(64'(n), 64'h8);
        set_mode(16'h0204);
        check(64'(bit_clock), 64'h0);
        for (int v = 0; v < 4; v++) begin
            vcm_drive_in = 2'(v);
            tick(2);
            check(64'(vcm_buffer_drive), 64'(v));
        end
        $display("test misc done");
    endtask
    initial begin
        tick(3);
        nrst = 1'b1;
        check(64'({mode_active, clock_div, vcm_buffer_drive, lanes}), 64'h0400);
        t_modes();
        t_gain();
        t_misc();
        close_out();
    end
endmodule
